// file: include/flash_ctrl_pkg.sv
// constants shared by the flash program and lock control block
// assumes an 8-bit register port and a 16-bit flash byte address
package flash_ctrl_pkg;

	// ----------------------------------------
	// unlock keys
	// ----------------------------------------
	localparam logic [7:0] KEY_FIRST = 8'hA5;
	localparam logic [7:0] KEY_SECOND = 8'hF1;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_PROGRAM_STORE_CONTROL = 8'h00;
	localparam logic [7:0] OFF_FLASH_UNLOCK_KEY = 8'h01;
	localparam logic [7:0] OFF_CACHE_CONTROL = 8'h02;
	localparam logic [7:0] OFF_RESET_SOURCE = 8'h03;
	localparam logic [7:0] OFF_LOCK_STATUS = 8'h04;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int BIT_WRITE_ENABLE = 0;
	localparam int BIT_ERASE_ENABLE = 1;
	localparam int BIT_BLOCK_WRITE = 0;
	localparam int BIT_POWER_ON = 1;
	localparam int BIT_FLASH_ERROR = 6;
	localparam int BIT_KEY_HALF = 0;
	localparam int BIT_KEY_OPEN = 1;
	localparam int BIT_KEY_DEAD = 2;
	localparam logic RST_ENABLE = 1'b0;
	localparam logic [7:0] RST_LOCK_EFFECTIVE = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	localparam logic [7:0] READ_RESERVED = 8'h00;

	// ----------------------------------------
	// flash geometry and lock byte
	// ----------------------------------------
	localparam int PAGE_SHIFT = 9;
	localparam logic [7:0] LOCK_NONE = 8'hFF;

	// ----------------------------------------
	// codes
	// ----------------------------------------
	localparam logic [1:0] FOP_PROGRAM = 2'h0;
	localparam logic [1:0] FOP_ERASE_PAGE = 2'h1;
	localparam logic [1:0] FOP_ERASE_ALL = 2'h2;

	localparam logic [1:0] DBG_READ = 2'h0;
	localparam logic [1:0] DBG_WRITE = 2'h1;
	localparam logic [1:0] DBG_ERASE = 2'h2;
	localparam logic [1:0] DBG_DEVICE_ERASE = 2'h3;

	localparam logic [1:0] ACC_READ = 2'h0;
	localparam logic [1:0] ACC_WRITE = 2'h1;
	localparam logic [1:0] ACC_ERASE = 2'h2;

	localparam logic [1:0] VERDICT_PERMIT = 2'h0;
	localparam logic [1:0] VERDICT_ERROR = 2'h1;
	localparam logic [1:0] VERDICT_IGNORE = 2'h2;

	typedef enum logic [3:0] {
		KEY_IDLE = 4'h1,
		KEY_HALF = 4'h2,
		KEY_OPEN = 4'h4,
		KEY_DEAD = 4'h8
	} key_state_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_BUSY = 3'h2,
		ST_ERROR = 3'h4
	} ctrl_state_e;

endpackage

// file: rtl/unlock_keys.sv
// key sequencer guarding firmware flash writes and erases
// assumes strobes from logic on the same clock
`timescale 1ns/1ps
module unlock_keys
(
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_key_wr,
	input wire logic [7:0] i_key_data,
	input wire logic i_attempt,
	output logic o_half,
	output logic o_open,
	output logic o_dead
);

	flash_ctrl_pkg::key_state_e state;
	flash_ctrl_pkg::key_state_e next_state;

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			flash_ctrl_pkg::KEY_IDLE:
			begin
				if (i_attempt)
					next_state = flash_ctrl_pkg::KEY_DEAD;
				else if (i_key_wr)
					next_state = (i_key_data == flash_ctrl_pkg::KEY_FIRST) ? flash_ctrl_pkg::KEY_HALF
						: flash_ctrl_pkg::KEY_DEAD;
			end
			flash_ctrl_pkg::KEY_HALF:
			begin
				if (i_attempt)
					next_state = flash_ctrl_pkg::KEY_DEAD;
				else if (i_key_wr)
					next_state = (i_key_data == flash_ctrl_pkg::KEY_SECOND) ? flash_ctrl_pkg::KEY_OPEN
						: flash_ctrl_pkg::KEY_DEAD;
			end
			flash_ctrl_pkg::KEY_OPEN:
			begin
				// one opening covers one data write only
				if (i_attempt)
					next_state = flash_ctrl_pkg::KEY_IDLE;
				else if (i_key_wr)
					next_state = flash_ctrl_pkg::KEY_DEAD;
			end
			default:
				next_state = flash_ctrl_pkg::KEY_DEAD;
		endcase
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
			state <= flash_ctrl_pkg::KEY_IDLE;
		else
			state <= next_state;
	end

	assign o_half = (state == flash_ctrl_pkg::KEY_HALF);
	assign o_open = (state == flash_ctrl_pkg::KEY_OPEN);
	assign o_dead = (state == flash_ctrl_pkg::KEY_DEAD);

endmodule // unlock_keys

// file: rtl/page_guard.sv
// page protection decision for one flash access
// assumes the lock byte seen at reset release and the live lock byte
`timescale 1ns/1ps
module page_guard
#(
	parameter int ADDR_W = 16,
	parameter int USER_BYTES = 16384
)
(
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [1:0] i_kind,
	input wire logic i_from_debug,
	input wire logic [ADDR_W-1:0] i_exec_addr,
	input wire logic [7:0] i_lock_eff,
	input wire logic [7:0] i_lock_now,
	output logic [1:0] o_verdict
);

	localparam int PAGE_BITS = ADDR_W - flash_ctrl_pkg::PAGE_SHIFT;
	localparam logic [PAGE_BITS-1:0] LOCK_PAGE = PAGE_BITS'((USER_BYTES - 1) >> flash_ctrl_pkg::PAGE_SHIFT);
	localparam logic [ADDR_W-1:0] LOCK_ADDR = ADDR_W'(USER_BYTES - 1);
	localparam logic [ADDR_W:0] USER_END = (ADDR_W + 1)'(USER_BYTES);

	// ----------------------------------------
	// page decode
	// ----------------------------------------
	function automatic logic page_locked(input logic [ADDR_W-1:0] a, input logic [7:0] lb);
		logic [PAGE_BITS-1:0] p;
		logic [7:0] n;
		begin
			p = a[ADDR_W-1:flash_ctrl_pkg::PAGE_SHIFT];
			n = ~lb;
			if (p == LOCK_PAGE)
				page_locked = (lb != flash_ctrl_pkg::LOCK_NONE);
			else
				page_locked = ({{(PAGE_BITS > 8 ? PAGE_BITS - 8 : 0){1'b0}}, n} > p);
		end
	endfunction

	wire reserved = ({1'b0, i_addr} >= USER_END);
	wire target_locked = page_locked(i_addr, i_lock_eff);
	wire exec_locked = page_locked(i_exec_addr, i_lock_eff);
	wire erase_lock_page = (i_kind == flash_ctrl_pkg::ACC_ERASE) &&
		(i_addr[ADDR_W-1:flash_ctrl_pkg::PAGE_SHIFT] == LOCK_PAGE);
	wire change_lock_byte = (i_kind == flash_ctrl_pkg::ACC_WRITE) && (i_addr == LOCK_ADDR) &&
		(i_lock_now != flash_ctrl_pkg::LOCK_NONE);
	wire [1:0] refuse = i_from_debug ? flash_ctrl_pkg::VERDICT_IGNORE : flash_ctrl_pkg::VERDICT_ERROR;

	// ----------------------------------------
	// verdict, first match wins
	// ----------------------------------------
	assign o_verdict =
		reserved ? flash_ctrl_pkg::VERDICT_IGNORE :
		erase_lock_page ? ((i_from_debug && i_lock_eff == flash_ctrl_pkg::LOCK_NONE) ?
			flash_ctrl_pkg::VERDICT_PERMIT : refuse) :
		change_lock_byte ? refuse :
		(target_locked && (i_from_debug || !exec_locked)) ? refuse :
		flash_ctrl_pkg::VERDICT_PERMIT;

endmodule // page_guard

// file: rtl/flash_program_and_lock_control.sv
// flash program sequencer with key unlock, block write cache and page locking
// assumes a flash array that finishes each operation with a done pulse and
// reads combinationally at the registered read address
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps

// Operation
// - keys A5 then F1 open one write
// - block write commits two bytes at once
// - cache first byte, commit on second
// - lone cached byte is never committed
// - data reads always go to RAM
// - write needs enable, erase needs both
// - inverted lock byte counts locked pages
// - lock page locked when any bit zero
// - unlocked code touching locked page resets
// - unlocked pages open to everyone
// - debug port violations are only ignored
// - firmware lock page erase resets
// - written lock byte changed afterwards only by debug erase
// - new lock byte acts after reset
// - reserved area reads junk, ignores changes
// - flash error reset sets error flag
// - interrupts held during flash operation
// - bad key sequence blocks until reset
// - lock closes after each operation
// - both enables make write erase page
// - cpu stalled during flash operation
module flash_program_and_lock_control
#(
	parameter int ADDR_W = 16,
	parameter int USER_BYTES = 16384
)
(
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_por_resetn,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	input wire logic i_xdata_wr,
	input wire logic i_xdata_rd,
	input wire logic [ADDR_W-1:0] i_xdata_addr,
	input wire logic [7:0] i_xdata_wdata,
	output logic o_external_data_ram_wr,
	output logic o_external_data_ram_rd,
	output logic [ADDR_W-1:0] o_external_data_ram_addr,
	output logic [7:0] o_external_data_ram_wdata,
	input wire logic i_code_rd,
	input wire logic [ADDR_W-1:0] i_code_addr,
	input wire logic [ADDR_W-1:0] i_exec_addr,
	output logic o_code_rvalid,
	output logic [7:0] o_code_rdata,
	input wire logic i_dbg_req,
	input wire logic [1:0] i_dbg_op,
	input wire logic [ADDR_W-1:0] i_dbg_addr,
	input wire logic [7:0] i_dbg_wdata,
	output logic o_dbg_done,
	output logic o_dbg_refused,
	output logic [7:0] o_dbg_rdata,
	output logic o_flash_req,
	output logic [1:0] o_flash_op,
	output logic [ADDR_W-1:0] o_flash_addr,
	output logic [15:0] o_flash_wdata,
	output logic [1:0] o_flash_wmask,
	input wire logic i_flash_done,
	output logic [ADDR_W-1:0] o_flash_raddr,
	input wire logic [7:0] i_flash_rdata,
	input wire logic [7:0] i_lock_byte,
	output logic o_cpu_stall,
	output logic o_irq_hold,
	output logic o_flash_error_reset
);

	if (USER_BYTES % (1 << flash_ctrl_pkg::PAGE_SHIFT) != 0 || USER_BYTES > (1 << ADDR_W) ||
		ADDR_W <= flash_ctrl_pkg::PAGE_SHIFT)
	begin : g_bad_geometry
		$error("flash user space must be whole pages inside the address range");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	flash_ctrl_pkg::ctrl_state_e state;
	flash_ctrl_pkg::ctrl_state_e next_state;
	logic write_enable, erase_enable, block_write;
	logic power_on_flag, flash_error_flag;
	logic [7:0] lock_eff;
	logic lock_loaded, cache_valid;
	logic [ADDR_W-1:0] cache_addr;
	logic [7:0] cache_data;
	logic op_from_debug, rd_pend, rd_dbg, rd_reserved;
	logic key_half, key_open, key_dead;
	logic [1:0] fw_verdict, dbg_verdict;

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	wire idle = (state == flash_ctrl_pkg::ST_IDLE);
	wire key_wr = i_reg_wr && (i_reg_addr == flash_ctrl_pkg::OFF_FLASH_UNLOCK_KEY);
	wire fw_flash_wr = idle && i_xdata_wr && write_enable;
	wire fw_code_rd = idle && i_code_rd && !fw_flash_wr;
	wire [1:0] fw_kind = fw_flash_wr ? (erase_enable ? flash_ctrl_pkg::ACC_ERASE : flash_ctrl_pkg::ACC_WRITE)
		: flash_ctrl_pkg::ACC_READ;
	wire [ADDR_W-1:0] fw_addr = fw_flash_wr ? i_xdata_addr : i_code_addr;
	wire fw_go = fw_flash_wr && key_open;
	wire fw_permit = fw_verdict == flash_ctrl_pkg::VERDICT_PERMIT;
	wire fw_error = (fw_flash_wr || fw_code_rd) && fw_verdict == flash_ctrl_pkg::VERDICT_ERROR;
	wire fw_erase = fw_go && fw_permit && erase_enable;
	wire fw_program = fw_go && fw_permit && !erase_enable;
	wire pair_hit = cache_valid && (i_xdata_addr == cache_addr + 1'b1);
	wire fw_commit_pair = fw_program && block_write && pair_hit;
	wire fw_cache_first = fw_program && block_write && !pair_hit;
	wire fw_single = fw_program && !block_write;
	wire fw_launch = fw_erase || fw_commit_pair || fw_single;

	wire [1:0] dbg_kind = (i_dbg_op == flash_ctrl_pkg::DBG_READ) ? flash_ctrl_pkg::ACC_READ :
		(i_dbg_op == flash_ctrl_pkg::DBG_WRITE) ? flash_ctrl_pkg::ACC_WRITE : flash_ctrl_pkg::ACC_ERASE;
	wire dbg_free = idle && !fw_flash_wr && !fw_code_rd;
	wire dbg_device_erase = i_dbg_op == flash_ctrl_pkg::DBG_DEVICE_ERASE;
	wire dbg_ok = dbg_free && (dbg_device_erase || dbg_verdict == flash_ctrl_pkg::VERDICT_PERMIT);
	wire dbg_read = i_dbg_req && dbg_ok && i_dbg_op == flash_ctrl_pkg::DBG_READ;
	wire dbg_launch = i_dbg_req && dbg_ok && i_dbg_op != flash_ctrl_pkg::DBG_READ;
	wire dbg_refuse = i_dbg_req && !dbg_ok;
	wire launch = fw_launch || dbg_launch;
	wire [1:0] launch_op = dbg_launch ? (dbg_device_erase ? flash_ctrl_pkg::FOP_ERASE_ALL :
		(i_dbg_op == flash_ctrl_pkg::DBG_ERASE) ? flash_ctrl_pkg::FOP_ERASE_PAGE : flash_ctrl_pkg::FOP_PROGRAM) :
		fw_erase ? flash_ctrl_pkg::FOP_ERASE_PAGE : flash_ctrl_pkg::FOP_PROGRAM;
	wire [ADDR_W-1:0] launch_addr = dbg_launch ? i_dbg_addr : fw_commit_pair ? cache_addr : i_xdata_addr;
	wire [15:0] launch_wdata = dbg_launch ? {8'hFF, i_dbg_wdata} :
		fw_commit_pair ? {i_xdata_wdata, cache_data} : {8'hFF, i_xdata_wdata};
	wire [1:0] launch_mask = fw_commit_pair ? 2'h3 : 2'h1;
	wire [7:0] reg_read_value =
		(i_reg_addr == flash_ctrl_pkg::OFF_PROGRAM_STORE_CONTROL) ?
			(8'(erase_enable) << flash_ctrl_pkg::BIT_ERASE_ENABLE) |
			(8'(write_enable) << flash_ctrl_pkg::BIT_WRITE_ENABLE) :
		(i_reg_addr == flash_ctrl_pkg::OFF_FLASH_UNLOCK_KEY) ?
			(8'(key_half) << flash_ctrl_pkg::BIT_KEY_HALF) | (8'(key_open) << flash_ctrl_pkg::BIT_KEY_OPEN) |
			(8'(key_dead) << flash_ctrl_pkg::BIT_KEY_DEAD) :
		(i_reg_addr == flash_ctrl_pkg::OFF_CACHE_CONTROL) ?
			(8'(block_write) << flash_ctrl_pkg::BIT_BLOCK_WRITE) :
		(i_reg_addr == flash_ctrl_pkg::OFF_RESET_SOURCE) ?
			(8'(flash_error_flag) << flash_ctrl_pkg::BIT_FLASH_ERROR) |
			(8'(power_on_flag) << flash_ctrl_pkg::BIT_POWER_ON) :
		(i_reg_addr == flash_ctrl_pkg::OFF_LOCK_STATUS) ? lock_eff :
		flash_ctrl_pkg::READ_UNMAPPED;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	unlock_keys u_keys
	(
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_key_wr(key_wr),
		.i_key_data(i_reg_wdata),
		.i_attempt(fw_flash_wr),
		.o_half(key_half),
		.o_open(key_open),
		.o_dead(key_dead)
	);

	page_guard #(.ADDR_W(ADDR_W), .USER_BYTES(USER_BYTES)) u_fw_guard
	(
		.i_addr(fw_addr),
		.i_kind(fw_kind),
		.i_from_debug(1'b0),
		.i_exec_addr(i_exec_addr),
		.i_lock_eff(lock_eff),
		.i_lock_now(i_lock_byte),
		.o_verdict(fw_verdict)
	);

	page_guard #(.ADDR_W(ADDR_W), .USER_BYTES(USER_BYTES)) u_dbg_guard
	(
		.i_addr(i_dbg_addr),
		.i_kind(dbg_kind),
		.i_from_debug(1'b1),
		.i_exec_addr(i_exec_addr),
		.i_lock_eff(lock_eff),
		.i_lock_now(i_lock_byte),
		.o_verdict(dbg_verdict)
	);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			flash_ctrl_pkg::ST_IDLE:
			begin
				if (fw_error && (fw_code_rd || key_open))
					next_state = flash_ctrl_pkg::ST_ERROR;
				else if (launch)
					next_state = flash_ctrl_pkg::ST_BUSY;
			end
			flash_ctrl_pkg::ST_BUSY:
			begin
				if (i_flash_done)
					next_state = flash_ctrl_pkg::ST_IDLE;
			end
			default:
				next_state = flash_ctrl_pkg::ST_ERROR;
		endcase
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
		begin
			write_enable <= flash_ctrl_pkg::RST_ENABLE;
			erase_enable <= flash_ctrl_pkg::RST_ENABLE;
			block_write <= flash_ctrl_pkg::RST_ENABLE;
			o_reg_rdata <= flash_ctrl_pkg::READ_UNMAPPED;
			lock_eff <= flash_ctrl_pkg::RST_LOCK_EFFECTIVE;
			lock_loaded <= 1'b0;
		end
		else
		begin
			if (i_reg_wr && i_reg_addr == flash_ctrl_pkg::OFF_PROGRAM_STORE_CONTROL)
			begin
				write_enable <= i_reg_wdata[flash_ctrl_pkg::BIT_WRITE_ENABLE];
				erase_enable <= i_reg_wdata[flash_ctrl_pkg::BIT_ERASE_ENABLE];
			end
			if (i_reg_wr && i_reg_addr == flash_ctrl_pkg::OFF_CACHE_CONTROL)
				block_write <= i_reg_wdata[flash_ctrl_pkg::BIT_BLOCK_WRITE];
			o_reg_rdata <= i_reg_rd ? reg_read_value : flash_ctrl_pkg::READ_UNMAPPED;
			// lock byte sampled once after each reset release
			if (!lock_loaded)
			begin
				lock_eff <= i_lock_byte;
				lock_loaded <= 1'b1;
			end
		end
	end

	// survives the flash error reset, reloaded only at power on, on entering the error state or by a reset source register write
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_por_resetn)
		begin
			power_on_flag <= 1'b1;
			flash_error_flag <= 1'b0;
		end
		else if (state == flash_ctrl_pkg::ST_ERROR)
		begin
			power_on_flag <= 1'b0;
			flash_error_flag <= 1'b1;
		end
		else if (i_resetn && i_reg_wr && i_reg_addr == flash_ctrl_pkg::OFF_RESET_SOURCE)
		begin
			// plain assignment of the whole register, as firmware is told to do
			power_on_flag <= i_reg_wdata[flash_ctrl_pkg::BIT_POWER_ON];
			flash_error_flag <= i_reg_wdata[flash_ctrl_pkg::BIT_FLASH_ERROR];
		end
	end

	// ----------------------------------------
	// block write cache
	// ----------------------------------------
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn || !block_write || !write_enable || erase_enable || fw_commit_pair)
			cache_valid <= 1'b0;
		else if (fw_cache_first)
			cache_valid <= 1'b1;
		if (fw_cache_first)
		begin
			cache_addr <= i_xdata_addr;
			cache_data <= i_xdata_wdata;
		end
	end

	// ----------------------------------------
	// flash array and cpu side
	// ----------------------------------------
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
		begin
			o_flash_req <= 1'b0;
			o_flash_op <= flash_ctrl_pkg::FOP_PROGRAM;
			o_flash_addr <= '0;
			o_flash_wdata <= 16'hFFFF;
			o_flash_wmask <= 2'h0;
			op_from_debug <= 1'b0;
			o_cpu_stall <= 1'b0;
			o_irq_hold <= 1'b0;
			o_flash_error_reset <= 1'b0;
			state <= flash_ctrl_pkg::ST_IDLE;
			o_external_data_ram_wr <= 1'b0;
			o_external_data_ram_rd <= 1'b0;
			o_external_data_ram_addr <= '0;
			o_external_data_ram_wdata <= 8'h00;
		end
		else
		begin
			if (idle && launch && next_state == flash_ctrl_pkg::ST_BUSY)
			begin
				o_flash_req <= 1'b1;
				o_flash_op <= launch_op;
				o_flash_addr <= launch_addr;
				o_flash_wdata <= launch_wdata;
				o_flash_wmask <= launch_mask;
				op_from_debug <= dbg_launch;
			end
			else if (i_flash_done)
				o_flash_req <= 1'b0;
			o_cpu_stall <= next_state == flash_ctrl_pkg::ST_BUSY;
			o_irq_hold <= next_state == flash_ctrl_pkg::ST_BUSY;
			o_flash_error_reset <= next_state == flash_ctrl_pkg::ST_ERROR;
			state <= next_state;
			// data space reads never see flash
			o_external_data_ram_wr <= i_xdata_wr && !write_enable;
			o_external_data_ram_rd <= i_xdata_rd;
			o_external_data_ram_addr <= i_xdata_addr;
			o_external_data_ram_wdata <= i_xdata_wdata;
		end
	end

	// ----------------------------------------
	// read pipe and debug answers
	// ----------------------------------------
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
		begin
			rd_pend <= 1'b0;
			rd_dbg <= 1'b0;
			rd_reserved <= 1'b0;
			o_flash_raddr <= '0;
			o_code_rvalid <= 1'b0;
			o_code_rdata <= 8'h00;
			o_dbg_rdata <= 8'h00;
			o_dbg_done <= 1'b0;
			o_dbg_refused <= 1'b0;
		end
		else
		begin
			rd_pend <= (fw_code_rd && !fw_error) || dbg_read;
			rd_dbg <= dbg_read;
			rd_reserved <= fw_code_rd && fw_verdict == flash_ctrl_pkg::VERDICT_IGNORE;
			if (fw_code_rd || dbg_read)
				o_flash_raddr <= fw_code_rd ? i_code_addr : i_dbg_addr;
			o_code_rvalid <= rd_pend && !rd_dbg;
			if (rd_pend && !rd_dbg)
				o_code_rdata <= rd_reserved ? flash_ctrl_pkg::READ_RESERVED : i_flash_rdata;
			if (rd_pend && rd_dbg)
				o_dbg_rdata <= i_flash_rdata;
			o_dbg_done <= (rd_pend && rd_dbg) || dbg_refuse ||
				(state == flash_ctrl_pkg::ST_BUSY && i_flash_done && op_from_debug);
			o_dbg_refused <= dbg_refuse;
		end
	end

endmodule // flash_program_and_lock_control

// file: verification/flash_array_model.sv
// flash array stand-in: byte memory that finishes each operation after a fixed wait
// assumes the controller holds its request until the cycle after done
`timescale 1ns/1ps
module flash_array_model
#(
	parameter int USER_BYTES = 2048,
	parameter int DELAY = 4
)
(
	input wire logic i_clk_sys,
	input wire logic i_req,
	input wire logic [1:0] i_op,
	input wire logic [15:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic [1:0] i_wmask,
	output logic o_done,
	input wire logic [15:0] i_raddr,
	output logic [7:0] o_rdata,
	output logic [7:0] o_lock
);
	logic [7:0] mem [USER_BYTES];
	int cnt = 0;
	assign o_rdata = mem[i_raddr % USER_BYTES];
	assign o_lock = mem[USER_BYTES-1];
	initial
	begin
		for (int i = 0; i < USER_BYTES; i++)
			mem[i] = (i >= 512 && i < 1024) ? 8'h00 : 8'hFF;
	end
	always @(posedge i_clk_sys)
	begin
		o_done <= 1'b0;
		if (!i_req)
			cnt <= 0;
		else if (cnt == DELAY)
		begin
			o_done <= 1'b1;
			cnt <= DELAY + 1;
			if (i_op == flash_ctrl_pkg::FOP_PROGRAM && i_wmask[0])
				mem[i_addr % USER_BYTES] &= i_wdata[7:0];
			if (i_op == flash_ctrl_pkg::FOP_PROGRAM && i_wmask[1])
				mem[(i_addr + 1) % USER_BYTES] &= i_wdata[15:8];
			for (int i = 0; i < USER_BYTES; i++)
				if (i_op == flash_ctrl_pkg::FOP_ERASE_ALL || (i_op == flash_ctrl_pkg::FOP_ERASE_PAGE && i >> 9 == i_addr >> 9))
					mem[i] = 8'hFF;
		end
		else if (cnt < DELAY)
			cnt <= cnt + 1;
	end
endmodule // flash_array_model

// file: verification/flash_program_and_lock_control_chk.sv
// assertions on the flash controller ports
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module flash_program_and_lock_control_chk
#(
	parameter int ADDR_W = 16
)
(
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_xdata_rd,
	input wire logic [ADDR_W-1:0] i_xdata_addr,
	input wire logic i_code_rd,
	input wire logic o_external_data_ram_rd,
	input wire logic o_external_data_ram_wr,
	input wire logic [ADDR_W-1:0] o_external_data_ram_addr,
	input wire logic o_code_rvalid,
	input wire logic o_flash_req,
	input wire logic [ADDR_W-1:0] o_flash_addr,
	input wire logic [15:0] o_flash_wdata,
	input wire logic i_flash_done,
	input wire logic o_cpu_stall,
	input wire logic o_irq_hold,
	input wire logic o_dbg_done,
	input wire logic o_dbg_refused,
	input wire logic o_flash_error_reset
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_resetn);
	sequence s_done_seen;
		o_flash_req && i_flash_done;
	endsequence
	sequence s_released;
		!o_flash_req && !o_cpu_stall;
	endsequence
	a_stall_with_req: assert property (o_flash_req |-> o_cpu_stall && o_irq_hold)
		else $error("stall or interrupt hold missing during flash operation");
	a_req_ends_done: assert property (s_done_seen |=> s_released)
		else $error("flash operation not released after done");
	a_op_held_stable: assert property (o_flash_req && $past(o_flash_req) |-> $stable(o_flash_addr) && $stable(o_flash_wdata))
		else $error("flash operation changed while pending");
	a_external_data_ram_read_always: assert property (i_xdata_rd |=> o_external_data_ram_rd && o_external_data_ram_addr == $past(i_xdata_addr))
		else $error("data read did not reach ram");
	a_ram_or_flash: assert property (o_external_data_ram_wr |-> !$rose(o_flash_req))
		else $error("data write went to ram and flash");
	a_refused_with_done: assert property (o_dbg_refused |-> o_dbg_done)
		else $error("debug refusal without done");
	a_error_sticks: assert property (o_flash_error_reset |=> o_flash_error_reset)
		else $error("flash error reset dropped before reset");
	a_code_read_answer: assert property (i_code_rd && !o_flash_req |-> ##2 (o_code_rvalid || o_flash_error_reset))
		else $error("code read not answered");
endmodule // flash_program_and_lock_control_chk
bind flash_program_and_lock_control flash_program_and_lock_control_chk #(.ADDR_W(ADDR_W)) chk_inst (.*);

// file: verification/flash_program_and_lock_control_test.sv
// self-checking bench for the flash program and lock controller
// assumes the flash array model and the bound checker
`timescale 1ns/1ps
module flash_program_and_lock_control_test;
	logic i_clk_sys = 0, i_resetn = 0, i_por_resetn = 0, i_reg_wr = 0, i_reg_rd = 0, i_xdata_wr = 0, i_xdata_rd = 0;
	logic i_code_rd = 0, i_dbg_req = 0, i_flash_done, o_external_data_ram_wr, o_external_data_ram_rd, o_code_rvalid, o_dbg_done, o_dbg_refused;
	logic o_flash_req, o_cpu_stall, o_irq_hold, o_flash_error_reset;
	logic [1:0] i_dbg_op = 0, o_flash_op, o_flash_wmask;
	logic [7:0] i_reg_addr = 0, i_reg_wdata = 0, i_xdata_wdata = 0, i_dbg_wdata = 0, o_reg_rdata, o_external_data_ram_wdata;
	logic [7:0] o_code_rdata, o_dbg_rdata, i_flash_rdata, i_lock_byte;
	logic [15:0] i_xdata_addr = 0, i_code_addr = 0, i_exec_addr = 16'h0400, i_dbg_addr = 0, o_external_data_ram_addr;
	logic [15:0] o_flash_addr, o_flash_wdata, o_flash_raddr;
	int n_mismatch = 0, total_checks = 0;
	flash_program_and_lock_control #(.USER_BYTES(2048)) flash_program_and_lock_control_inst (.*);
	flash_array_model flash_array_model_inst (.i_clk_sys(i_clk_sys), .i_req(o_flash_req), .i_op(o_flash_op),
		.i_addr(o_flash_addr), .i_wdata(o_flash_wdata), .i_wmask(o_flash_wmask), .o_done(i_flash_done),
		.i_raddr(o_flash_raddr), .o_rdata(i_flash_rdata), .o_lock(i_lock_byte));
	initial
		forever #25 i_clk_sys = ~i_clk_sys;
	function automatic logic [7:0] fm(input int a);
		return flash_array_model_inst.mem[a];
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		if (n_mismatch == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic rst(input logic p);
		@(posedge i_clk_sys);
		i_resetn <= 1'b0;
		i_por_resetn <= !p;
		repeat (6) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		i_por_resetn <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge i_clk_sys);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_reg_rd <= 1'b0;
		#1 chk(o_reg_rdata & m, e);
	endtask
	task automatic xw(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_xdata_addr <= a;
		i_xdata_wdata <= d;
		i_xdata_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_xdata_wr <= 1'b0;
	endtask
	task automatic fw(input logic [15:0] a, input logic [7:0] d, input logic w);
		reg_wr(8'h01, flash_ctrl_pkg::KEY_FIRST);
		reg_wr(8'h01, flash_ctrl_pkg::KEY_SECOND);
		xw(a, d);
		#1;
		for (int i = 0; w && i < 40 && o_flash_req !== 1'b0; i++)
			@(posedge i_clk_sys) #1;
		chk(w && o_flash_req !== 1'b0, 1'b0);
	endtask
	task automatic cr(input logic [15:0] a);
		@(posedge i_clk_sys);
		i_code_addr <= a;
		i_code_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_code_rd <= 1'b0;
		@(posedge i_clk_sys) #1;
	endtask
	task automatic dbg(input logic [1:0] op, input logic [15:0] a);
		@(posedge i_clk_sys);
		i_dbg_op <= op;
		i_dbg_addr <= a;
		i_dbg_req <= 1'b1;
		@(posedge i_clk_sys);
		i_dbg_req <= 1'b0;
		#1;
		for (int i = 0; i < 40 && o_dbg_done !== 1'b1; i++)
			@(posedge i_clk_sys) #1;
		chk(o_dbg_done, 1'b1);
	endtask
	initial
	begin
		repeat (5000) @(posedge i_clk_sys);
		n_mismatch++;
		final_report;
	end
	initial
	begin
		rst(1'b1);
		reg_rd(8'h03, 8'hFF, 8'h02);
		reg_rd(8'h04, 8'hFF, 8'hFF);
		xw(16'h0030, 8'h77);
		#1 chk({o_external_data_ram_wr, o_flash_req, o_external_data_ram_wdata}, 10'h277);
		reg_wr(8'h00, 8'h01);
		fw(16'h0410, 8'h3C, 1'b1);
		chk(fm(16'h0410), 8'h3C);
		reg_rd(8'h01, 8'h07, 8'h00);
		xw(16'h0411, 8'h55);
		repeat (3) @(posedge i_clk_sys) #1;
		chk({o_flash_req, fm(16'h0411)}, 9'h0FF);
		reg_rd(8'h01, 8'h07, 8'h04);
		rst(1'b0);
		reg_wr(8'h00, 8'h01);
		reg_wr(8'h02, 8'h01);
		fw(16'h0420, 8'h11, 1'b0);
		repeat (3) @(posedge i_clk_sys) #1;
		chk(o_flash_req, 1'b0);
		fw(16'h0421, 8'h22, 1'b1);
		chk({fm(16'h0420), fm(16'h0421)}, 16'h1122);
		reg_wr(8'h02, 8'h00);
		reg_wr(8'h00, 8'h03);
		fw(16'h0205, 8'h00, 1'b1);
		chk({fm(16'h0200), fm(16'h03FF)}, 16'hFFFF);
		reg_wr(8'h00, 8'h01);
		fw(16'h07FF, 8'hFE, 1'b1);
		reg_rd(8'h04, 8'hFF, 8'hFF);
		rst(1'b0);
		reg_rd(8'h04, 8'hFF, 8'hFE);
		dbg(flash_ctrl_pkg::DBG_WRITE, 16'h0005);
		chk({o_dbg_refused, o_flash_error_reset}, 2'b10);
		dbg(flash_ctrl_pkg::DBG_READ, 16'h0410);
		chk({o_dbg_refused, o_dbg_rdata}, 9'h03C);
		cr(16'h0900);
		chk({o_code_rvalid, o_code_rdata}, 9'h100);
		@(posedge i_clk_sys);
		i_xdata_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_xdata_rd <= 1'b0;
		#1 chk(o_external_data_ram_rd, 1'b1);
		i_exec_addr <= 16'h0000;
		cr(16'h0005);
		chk({o_flash_error_reset, o_code_rvalid, o_code_rdata}, 10'h1FF);
		i_exec_addr <= 16'h0400;
		cr(16'h0005);
		chk(o_flash_error_reset, 1'b1);
		rst(1'b0);
		reg_rd(8'h03, 8'h40, 8'h40);
		i_exec_addr <= 16'h0000;
		reg_wr(8'h00, 8'h01);
		fw(16'h07FF, 8'h00, 1'b0);
		repeat (2) @(posedge i_clk_sys) #1;
		chk(o_flash_error_reset, 1'b1);
		rst(1'b0);
		dbg(flash_ctrl_pkg::DBG_DEVICE_ERASE, 16'h0000);
		chk({o_dbg_refused, fm(2047)}, 9'h0FF);
		reg_wr(8'h03, 8'h02);
		reg_rd(8'h03, 8'hFF, 8'h02);
		final_report;
	end
endmodule // flash_program_and_lock_control_test
